// ===== shared/cds_alu_pkg.sv
// Constants, opcode patterns and types of the compare and divide-step unit.
// Assumes a 16-bit instruction word and 32-bit general registers.
`default_nettype none

package cds_alu_pkg;

	//////////////////////////////////////////////////////////////////////////
	// Instruction fields.
	localparam int DST_MSB = 11;
	localparam int DST_LSB = 8;
	localparam int SRC_MSB = 7;
	localparam int SRC_LSB = 4;
	localparam int IMM_MSB = 7;
	localparam int IMM_LSB = 0;
	localparam logic [3:0] ZERO_INDEX = 4'h0;

	//////////////////////////////////////////////////////////////////////////
	// Decode masks and patterns.
	localparam logic [15:0] MASK_TWO_REG = 16'hF00F;
	localparam logic [15:0] MASK_ONE_REG = 16'hF0FF;
	localparam logic [15:0] MASK_IMM = 16'hFF00;
	localparam logic [15:0] MASK_FULL = 16'hFFFF;
	localparam logic [15:0] PAT_COMPARE_EQUAL = 16'h3000;
	localparam logic [15:0] PAT_COMPARE_UNSIGNED_HIGHER_SAME = 16'h3002;
	localparam logic [15:0] PAT_COMPARE_SIGNED_GE = 16'h3003;
	localparam logic [15:0] PAT_DIVIDE_STEP = 16'h3004;
	localparam logic [15:0] PAT_COMPARE_UNSIGNED_HIGHER = 16'h3006;
	localparam logic [15:0] PAT_COMPARE_SIGNED_GT = 16'h3007;
	localparam logic [15:0] PAT_SIGNED_DIVIDE_INIT = 16'h2007;
	localparam logic [15:0] PAT_COMPARE_BYTE_MATCH = 16'h200C;
	localparam logic [15:0] PAT_TEST_POSITIVE = 16'h4015;
	localparam logic [15:0] PAT_TEST_NON_NEGATIVE = 16'h4011;
	localparam logic [15:0] PAT_COMPARE_EQUAL_IMM = 16'h8800;
	localparam logic [15:0] PAT_UNSIGNED_DIVIDE_INIT = 16'h0019;

	//////////////////////////////////////////////////////////////////////////
	// Program counter step and reset values.
	localparam logic [31:0] PC_STEP = 32'h00000002;
	localparam logic RESET_FLAG = 1'b0;
	localparam logic [31:0] RESET_WORD = 32'h00000000;
	localparam logic [3:0] RESET_INDEX = 4'h0;

	//////////////////////////////////////////////////////////////////////////
	// Operations.
	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_COMPARE_EQUAL = 4'h1,
		OP_COMPARE_SIGNED_GE = 4'h2,
		OP_COMPARE_SIGNED_GT = 4'h3,
		OP_COMPARE_UNSIGNED_HIGHER = 4'h4,
		OP_COMPARE_UNSIGNED_HIGHER_SAME = 4'h5,
		OP_TEST_POSITIVE = 4'h6,
		OP_TEST_NON_NEGATIVE = 4'h7,
		OP_COMPARE_BYTE_MATCH = 4'h8,
		OP_COMPARE_EQUAL_IMM = 4'h9,
		OP_SIGNED_DIVIDE_INIT = 4'hA,
		OP_UNSIGNED_DIVIDE_INIT = 4'hB,
		OP_DIVIDE_STEP = 4'hC
	} cds_op_t;

	function automatic logic cds_match(input logic [15:0] word,
		input logic [15:0] mask, input logic [15:0] pattern);
		return (word & mask) == pattern;
	endfunction

	function automatic cds_op_t cds_decode(input logic [15:0] word);
		cds_op_t op;
		op = OP_NONE;
		if (cds_match(word, MASK_TWO_REG, PAT_COMPARE_EQUAL)) begin
			op = OP_COMPARE_EQUAL;
		end else if (cds_match(word, MASK_TWO_REG, PAT_COMPARE_SIGNED_GE)) begin
			op = OP_COMPARE_SIGNED_GE;
		end else if (cds_match(word, MASK_TWO_REG, PAT_COMPARE_SIGNED_GT)) begin
			op = OP_COMPARE_SIGNED_GT;
		end else if (cds_match(word, MASK_TWO_REG,
			PAT_COMPARE_UNSIGNED_HIGHER)) begin
			op = OP_COMPARE_UNSIGNED_HIGHER;
		end else if (cds_match(word, MASK_TWO_REG,
			PAT_COMPARE_UNSIGNED_HIGHER_SAME)) begin
			op = OP_COMPARE_UNSIGNED_HIGHER_SAME;
		end else if (cds_match(word, MASK_ONE_REG, PAT_TEST_POSITIVE)) begin
			op = OP_TEST_POSITIVE;
		end else if (cds_match(word, MASK_ONE_REG, PAT_TEST_NON_NEGATIVE)) begin
			op = OP_TEST_NON_NEGATIVE;
		end else if (cds_match(word, MASK_TWO_REG, PAT_COMPARE_BYTE_MATCH)) begin
			op = OP_COMPARE_BYTE_MATCH;
		end else if (cds_match(word, MASK_IMM, PAT_COMPARE_EQUAL_IMM)) begin
			op = OP_COMPARE_EQUAL_IMM;
		end else if (cds_match(word, MASK_TWO_REG, PAT_SIGNED_DIVIDE_INIT)) begin
			op = OP_SIGNED_DIVIDE_INIT;
		end else if (cds_match(word, MASK_FULL, PAT_UNSIGNED_DIVIDE_INIT)) begin
			op = OP_UNSIGNED_DIVIDE_INIT;
		end else if (cds_match(word, MASK_TWO_REG, PAT_DIVIDE_STEP)) begin
			op = OP_DIVIDE_STEP;
		end
		return op;
	endfunction

endpackage

`default_nettype wire

// ===== shared/cds_op_if.sv
// Operand and result bundle between the issue logic and its two units.
// Assumes all three parties sit on the same clock; the bundle is wiring only.
`timescale 1ns/1ps
`default_nettype none

interface cds_op_if;
	cds_alu_pkg::cds_op_t op;
	logic [31:0] dstOperand;
	logic [31:0] srcOperand;
	logic condIn;
	logic quotIn;
	logic signIn;
	logic cmpResult;
	logic [31:0] divData;
	logic divQuot;
	logic divCond;

	modport issue(
		output op, dstOperand, srcOperand, condIn, quotIn, signIn,
		input cmpResult, divData, divQuot, divCond
	);
	modport cmpUnit(
		input op, dstOperand, srcOperand,
		output cmpResult
	);
	modport divUnit(
		input dstOperand, srcOperand, condIn, quotIn, signIn,
		output divData, divQuot, divCond
	);
endinterface

`default_nettype wire

// ===== hw/cds_compare.sv
// Combinational comparator for every compare and test operation.
// Assumes the issue logic has already put the immediate in the source slot.
`timescale 1ns/1ps
`default_nettype none

module cds_compare (
	// Operands and result.
	cds_op_if.cmpUnit bus
);

	logic [31:0] diff;

	always_comb begin
		diff = bus.dstOperand ^ bus.srcOperand;
		case (bus.op)
			cds_alu_pkg::OP_COMPARE_EQUAL,
			cds_alu_pkg::OP_COMPARE_EQUAL_IMM: begin
				bus.cmpResult = (diff == 32'h00000000);
			end
			cds_alu_pkg::OP_COMPARE_SIGNED_GE: begin
				bus.cmpResult = $signed(bus.dstOperand) >=
					$signed(bus.srcOperand);
			end
			cds_alu_pkg::OP_COMPARE_SIGNED_GT: begin
				bus.cmpResult = $signed(bus.dstOperand) >
					$signed(bus.srcOperand);
			end
			cds_alu_pkg::OP_COMPARE_UNSIGNED_HIGHER: begin
				bus.cmpResult = bus.dstOperand > bus.srcOperand;
			end
			cds_alu_pkg::OP_COMPARE_UNSIGNED_HIGHER_SAME: begin
				bus.cmpResult = bus.dstOperand >= bus.srcOperand;
			end
			cds_alu_pkg::OP_TEST_POSITIVE: begin
				bus.cmpResult = !bus.dstOperand[31] &&
					(bus.dstOperand != 32'h00000000);
			end
			cds_alu_pkg::OP_TEST_NON_NEGATIVE: begin
				bus.cmpResult = !bus.dstOperand[31];
			end
			cds_alu_pkg::OP_COMPARE_BYTE_MATCH: begin
				bus.cmpResult = (diff[31:24] == 8'h00) ||
					(diff[23:16] == 8'h00) || (diff[15:8] == 8'h00) ||
					(diff[7:0] == 8'h00);
			end
			default: begin
				bus.cmpResult = 1'b0;
			end
		endcase
	end

endmodule

`default_nettype wire

// ===== hw/cds_divstep.sv
// Combinational one-bit non-restoring divide step.
// Assumes the issue logic supplies current flags and forwarded operands.
`timescale 1ns/1ps
`default_nettype none

module cds_divstep (
	// Operands, flags and results.
	cds_op_if.divUnit bus
);

	logic topBit;
	logic [31:0] shifted;
	logic [32:0] sum;
	logic carry;

	always_comb begin
		topBit = bus.dstOperand[31];
		shifted = {bus.dstOperand[30:0], bus.condIn};
		// Bit 32 of the 33-bit result is the borrow or the carry out.
		if (bus.quotIn == bus.signIn) begin
			sum = {1'b0, shifted} - {1'b0, bus.srcOperand};
		end else begin
			sum = {1'b0, shifted} + {1'b0, bus.srcOperand};
		end
		carry = sum[32];
		bus.divData = sum[31:0];
		bus.divQuot = topBit ^ carry ^ bus.signIn;
		bus.divCond = (bus.divQuot == bus.signIn);
	end

endmodule

`default_nettype wire

// ===== hw/cds_alu.sv
// Compare and divide-step execution unit of a 32-bit core.
// Assumes the decoder presents one instruction per cycle with its register
// values read combinationally from the register file on the same clock.
//
// Functional notes
// - Compares write the condition flag and never modify registers.
// - Register equal compare sets the flag on identical words, one cycle.
// - Signed greater-or-equal and greater-than use two's complement.
// - Unsigned higher and higher-or-same compares use unsigned magnitudes.
// - Positive test needs value above zero; non-negative needs zero or more.
// - Byte match sets the flag when any same-position byte pair is equal.
// - Immediate equal sign-extends eight bits against register zero.
// - Signed init copies both sign bits to flags; condition is their xor.
// - Unsigned init clears divisor-sign, quotient and condition flags.
// - Divide step shifts out the top bit and shifts in the old condition flag.
// - Subtract when old quotient equals divisor sign, else add.
// - After a step the condition flag shows quotient equal to divisor sign.
// - No zero divide or overflow detection and no remainder is produced.
`timescale 1ns/1ps
`default_nettype none

module cds_alu (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Instruction issue.
	input wire logic instrValid,
	input wire logic [15:0] instr,
	input wire logic [31:0] pcIn,
	// Register file read values.
	input wire logic [31:0] dstValue,
	input wire logic [31:0] srcValue,
	input wire logic [31:0] zeroValue,
	// Status flags.
	output logic condFlag,
	output logic quotFlag,
	output logic signFlag,
	// Completion and write-back.
	output logic accepted,
	output logic [31:0] pcOut,
	output logic resultWrite,
	output logic [3:0] resultIndex,
	output logic [31:0] resultData
);

	//////////////////////////////////////////////////////////////////////////
	// State.

	typedef struct packed {
		logic cond;
		logic quot;
		logic sign;
		logic accepted;
		logic [31:0] pc;
		logic write;
		logic [3:0] index;
		logic [31:0] data;
	} cds_state_t;

	cds_state_t cur;
	cds_state_t next_cur;

	cds_op_if opBus();

	cds_alu_pkg::cds_op_t op;
	logic [3:0] dstIndex;
	logic [3:0] srcIndex;
	logic [31:0] dstFwd;
	logic [31:0] srcFwd;
	logic [31:0] zeroFwd;
	logic [31:0] immWide;

	//////////////////////////////////////////////////////////////////////////
	// Forwarding.

	// The register file only sees a step result one cycle after it leaves
	// this unit, so a back-to-back step would read a stale dividend without
	// this bypass.
	function automatic logic [31:0] cds_forward(input logic [31:0] value,
		input logic [3:0] index, input logic wrote,
		input logic [3:0] wroteIndex, input logic [31:0] wroteData);
		logic [31:0] chosen;
		chosen = value;
		if (wrote && (wroteIndex == index)) begin
			chosen = wroteData;
		end
		return chosen;
	endfunction

	always_comb begin
		dstIndex = instr[cds_alu_pkg::DST_MSB:cds_alu_pkg::DST_LSB];
		srcIndex = instr[cds_alu_pkg::SRC_MSB:cds_alu_pkg::SRC_LSB];
		dstFwd = cds_forward(dstValue, dstIndex, cur.write, cur.index,
			cur.data);
		srcFwd = cds_forward(srcValue, srcIndex, cur.write, cur.index,
			cur.data);
		zeroFwd = cds_forward(zeroValue, cds_alu_pkg::ZERO_INDEX, cur.write,
			cur.index, cur.data);
		immWide = {{24{instr[cds_alu_pkg::IMM_MSB]}},
			instr[cds_alu_pkg::IMM_MSB:cds_alu_pkg::IMM_LSB]};
		if (instrValid) begin
			op = cds_alu_pkg::cds_decode(instr);
		end else begin
			op = cds_alu_pkg::OP_NONE;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Operand routing to the units.

	// The immediate form compares register zero against the immediate, so
	// register zero takes the destination slot and the immediate the source.
	assign opBus.op = op;
	assign opBus.dstOperand =
		(op == cds_alu_pkg::OP_COMPARE_EQUAL_IMM) ? zeroFwd : dstFwd;
	assign opBus.srcOperand =
		(op == cds_alu_pkg::OP_COMPARE_EQUAL_IMM) ? immWide : srcFwd;
	assign opBus.condIn = cur.cond;
	assign opBus.quotIn = cur.quot;
	assign opBus.signIn = cur.sign;

	cds_compare compareUnit (
		.bus(opBus.cmpUnit)
	);

	cds_divstep divideUnit (
		.bus(opBus.divUnit)
	);

	//////////////////////////////////////////////////////////////////////////
	// Next state.

	always_comb begin
		next_cur = cur;
		next_cur.accepted = 1'b0;
		next_cur.write = 1'b0;
		if (op != cds_alu_pkg::OP_NONE) begin
			next_cur.accepted = 1'b1;
			next_cur.pc = pcIn + cds_alu_pkg::PC_STEP;
		end
		case (op)
			cds_alu_pkg::OP_COMPARE_EQUAL,
			cds_alu_pkg::OP_COMPARE_SIGNED_GE,
			cds_alu_pkg::OP_COMPARE_SIGNED_GT,
			cds_alu_pkg::OP_COMPARE_UNSIGNED_HIGHER,
			cds_alu_pkg::OP_COMPARE_UNSIGNED_HIGHER_SAME,
			cds_alu_pkg::OP_TEST_POSITIVE,
			cds_alu_pkg::OP_TEST_NON_NEGATIVE,
			cds_alu_pkg::OP_COMPARE_BYTE_MATCH,
			cds_alu_pkg::OP_COMPARE_EQUAL_IMM: begin
				// Compares write only the flag; no register write-back.
				next_cur.cond = opBus.cmpResult;
			end
			cds_alu_pkg::OP_SIGNED_DIVIDE_INIT: begin
				next_cur.quot = dstFwd[31];
				next_cur.sign = srcFwd[31];
				next_cur.cond = dstFwd[31] ^ srcFwd[31];
			end
			cds_alu_pkg::OP_UNSIGNED_DIVIDE_INIT: begin
				next_cur.quot = 1'b0;
				next_cur.sign = 1'b0;
				next_cur.cond = 1'b0;
			end
			cds_alu_pkg::OP_DIVIDE_STEP: begin
				// Zero divisor and overflow pass through unflagged; software
				// must screen them before the sequence starts.
				next_cur.quot = opBus.divQuot;
				next_cur.cond = opBus.divCond;
				next_cur.write = 1'b1;
				next_cur.index = dstIndex;
				next_cur.data = opBus.divData;
			end
			default: begin
				next_cur.accepted = 1'b0;
			end
		endcase
	end

	//////////////////////////////////////////////////////////////////////////
	// Registers.

	always_ff @(posedge clk) begin
		if (rst) begin
			cur.cond <= cds_alu_pkg::RESET_FLAG;
			cur.quot <= cds_alu_pkg::RESET_FLAG;
			cur.sign <= cds_alu_pkg::RESET_FLAG;
			cur.accepted <= cds_alu_pkg::RESET_FLAG;
			cur.pc <= cds_alu_pkg::RESET_WORD;
			cur.write <= cds_alu_pkg::RESET_FLAG;
			cur.index <= cds_alu_pkg::RESET_INDEX;
			cur.data <= cds_alu_pkg::RESET_WORD;
		end else begin
			cur <= next_cur;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Outputs.

	assign condFlag = cur.cond;
	assign quotFlag = cur.quot;
	assign signFlag = cur.sign;
	assign accepted = cur.accepted;
	assign pcOut = cur.pc;
	assign resultWrite = cur.write;
	assign resultIndex = cur.index;
	assign resultData = cur.data;

endmodule

`default_nettype wire

// ===== test/cds_regfile_model.sv
// Register file model that feeds operands to the compare and divide unit.
// Assumes the bench loads every register it reads before issuing.
`timescale 1ns/1ps
`default_nettype none

module cds_regfile_model (
	// Clock.
	input wire logic clk,
	// Operand read.
	input wire logic [15:0] instr,
	output logic [31:0] dstValue,
	output logic [31:0] srcValue,
	output logic [31:0] zeroValue,
	// Write-back from the unit.
	input wire logic resultWrite,
	input wire logic [3:0] resultIndex,
	input wire logic [31:0] resultData,
	// Direct load from the bench.
	input wire logic loadEn,
	input wire logic [3:0] loadIndex,
	input wire logic [31:0] loadData
);
	logic [31:0] regs [16];

	// Registers start at zero so that idle reads never carry unknowns.
	initial begin
		foreach (regs[i]) begin
			regs[i] = 32'h0000_0000;
		end
	end

	always @(posedge clk) begin
		if (resultWrite) begin
			regs[resultIndex] <= resultData;
		end else if (loadEn) begin
			regs[loadIndex] <= loadData;
		end
	end

	assign dstValue = regs[instr[11:8]];
	assign srcValue = regs[instr[7:4]];
	assign zeroValue = regs[0];
endmodule

`default_nettype wire

// ===== test/cds_alu_properties.sv
// Concurrent checks on the ports of the compare and divide-step unit.
// Assumes one clock and the synchronous reset of the unit.
`timescale 1ns/1ps
`default_nettype none

module cds_alu_checker (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Issue and operands.
	input wire logic instrValid,
	input wire logic [15:0] instr,
	input wire logic [31:0] pcIn,
	input wire logic [31:0] dstValue,
	input wire logic [31:0] srcValue,
	input wire logic [31:0] zeroValue,
	// Results.
	input wire logic condFlag,
	input wire logic quotFlag,
	input wire logic signFlag,
	input wire logic accepted,
	input wire logic [31:0] pcOut,
	input wire logic resultWrite,
	input wire logic [3:0] resultIndex,
	input wire logic [31:0] resultData
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// Operand checks skip cycles that take a forwarded step result.
	logic live;
	logic [15:0] opTwo;
	assign live = instrValid && !resultWrite;
	assign opTwo = instr & cds_alu_pkg::MASK_TWO_REG;

	sequence s_step_issue;
		instrValid && opTwo == cds_alu_pkg::PAT_DIVIDE_STEP;
	endsequence
	sequence s_step_done;
		accepted && resultWrite;
	endsequence

	property p_step_write;
		s_step_issue |=> s_step_done ##0 resultIndex == $past(instr[11:8]);
	endproperty
	a_step_write: assert property (p_step_write)
		else $error("step write");
	property p_step_cond;
		s_step_issue |=> condFlag == (quotFlag == signFlag)
			&& $stable(signFlag);
	endproperty
	a_step_cond: assert property (p_step_cond)
		else $error("step flag");
	property p_eq;
		live && opTwo == cds_alu_pkg::PAT_COMPARE_EQUAL
			|=> condFlag == $past(dstValue == srcValue);
	endproperty
	a_eq: assert property (p_eq)
		else $error("equal compare");
	property p_ge;
		live && opTwo == cds_alu_pkg::PAT_COMPARE_SIGNED_GE
			|=> condFlag == $past($signed(dstValue) >= $signed(srcValue));
	endproperty
	a_ge: assert property (p_ge)
		else $error("signed compare");
	property p_hi;
		live && opTwo == cds_alu_pkg::PAT_COMPARE_UNSIGNED_HIGHER
			|=> condFlag == $past(dstValue > srcValue);
	endproperty
	a_hi: assert property (p_hi)
		else $error("unsigned compare");
	property p_imm;
		live && (instr & cds_alu_pkg::MASK_IMM)
			== cds_alu_pkg::PAT_COMPARE_EQUAL_IMM
			|=> condFlag == $past(zeroValue == {{24{instr[7]}}, instr[7:0]});
	endproperty
	a_imm: assert property (p_imm)
		else $error("immediate compare");
	property p_uinit;
		instrValid && instr == cds_alu_pkg::PAT_UNSIGNED_DIVIDE_INIT
			|=> !condFlag && !quotFlag && !signFlag;
	endproperty
	a_uinit: assert property (p_uinit)
		else $error("unsigned init");
	property p_sinit;
		live && opTwo == cds_alu_pkg::PAT_SIGNED_DIVIDE_INIT
			|=> quotFlag == $past(dstValue[31])
			&& signFlag == $past(srcValue[31])
			&& condFlag == (quotFlag ^ signFlag);
	endproperty
	a_sinit: assert property (p_sinit)
		else $error("signed init");
	property p_pc;
		accepted |-> pcOut == $past(pcIn) + cds_alu_pkg::PC_STEP;
	endproperty
	a_pc: assert property (p_pc)
		else $error("program counter");
	property p_idle;
		!instrValid |=> !accepted && !resultWrite;
	endproperty
	a_idle: assert property (p_idle)
		else $error("idle cycle");
	property p_hold;
		!accepted && !$past(rst) |-> $stable(condFlag) && $stable(quotFlag)
			&& $stable(signFlag) && $stable(pcOut);
	endproperty
	a_hold: assert property (p_hold)
		else $error("flags moved");
endmodule

////////////////////////////////////////////////////////////////////////////
bind cds_alu cds_alu_checker i_cds_alu_checker (
	.clk(clk), .rst(rst), .instrValid(instrValid), .instr(instr),
	.pcIn(pcIn), .dstValue(dstValue), .srcValue(srcValue),
	.zeroValue(zeroValue), .condFlag(condFlag), .quotFlag(quotFlag),
	.signFlag(signFlag), .accepted(accepted), .pcOut(pcOut),
	.resultWrite(resultWrite), .resultIndex(resultIndex),
	.resultData(resultData)
);

`default_nettype wire

// ===== test/cds_alu_tb.sv
// Self-checking bench of the compare and divide-step unit.
// Assumes the unit answers one cycle after each taken instruction.
`timescale 1ns/1ps
`default_nettype none

module cds_alu_tb;
	logic clk, rst, instrValid, loadEn, condFlag, quotFlag, signFlag;
	logic accepted, resultWrite;
	logic [15:0] instr;
	logic [3:0] resultIndex, loadIndex;
	logic [31:0] pcIn, dstValue, srcValue, zeroValue, pcOut, resultData;
	logic [31:0] loadData, pc;
	int fails, checkCount;

	cds_alu i_cds_alu (.clk(clk), .rst(rst), .instrValid(instrValid),
		.instr(instr), .pcIn(pcIn), .dstValue(dstValue), .srcValue(srcValue),
		.zeroValue(zeroValue), .condFlag(condFlag), .quotFlag(quotFlag),
		.signFlag(signFlag), .accepted(accepted), .pcOut(pcOut),
		.resultWrite(resultWrite), .resultIndex(resultIndex),
		.resultData(resultData));
	cds_regfile_model i_cds_regfile_model (.clk(clk), .instr(instr),
		.dstValue(dstValue), .srcValue(srcValue), .zeroValue(zeroValue),
		.resultWrite(resultWrite), .resultIndex(resultIndex),
		.resultData(resultData), .loadEn(loadEn), .loadIndex(loadIndex),
		.loadData(loadData));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////
	task end_of_test;
		if (fails == 0 && checkCount > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	task chk1(input logic got, input logic exp);
		checkCount++;
		if (got !== exp) begin
			fails++;
			$display("Error %0t: bit %b, want %b", $time, got, exp);
		end
	endtask

	task chk32(input logic [31:0] got, input logic [31:0] exp);
		checkCount++;
		if (got !== exp) begin
			fails++;
			$display("Error %0t: word %h, want %h", $time, got, exp);
		end
	endtask

	task load(input logic [3:0] i, input logic [31:0] d);
		@(negedge clk);
		loadEn = 1'b1;
		loadIndex = i;
		loadData = d;
		@(negedge clk);
		loadEn = 1'b0;
	endtask

	task iss(input logic [15:0] w);
		@(negedge clk);
		instrValid = 1'b1;
		instr = w;
		pcIn = pc;
		pc = pc + 32'h0000_0002;
	endtask

	task idle;
		@(negedge clk);
		instrValid = 1'b0;
	endtask

	task t_cmp(input logic [15:0] w, input logic [31:0] a, b, input logic e);
		load(4'h0, a);
		load(4'h1, a);
		load(4'h2, b);
		iss(w);
		idle;
		chk1(accepted, 1'b1);
		chk1(condFlag, e);
		chk32(pcOut, pc);
		chk1(resultWrite, 1'b0);
	endtask

	task t_refuse;
		logic c;
		logic [31:0] p;
		c = condFlag;
		p = pcOut;
		iss(16'h0009);
		idle;
		chk1(accepted, 1'b0);
		chk32(pcOut, p);
		@(negedge clk);
		instr = 16'h3120;
		@(negedge clk);
		chk1(accepted, 1'b0);
		chk1(condFlag, c);
	endtask

	// Back-to-back steps lean on forwarding of each new dividend.
	task t_div(input logic [15:0] w, input logic [31:0] a, d, input int n);
		logic [31:0] rn;
		logic [32:0] s;
		logic q, t, m, top;
		load(4'h0, d);
		load(4'h1, a);
		rn = a;
		q = (w == 16'h2107) ? a[31] : 1'b0;
		m = (w == 16'h2107) ? d[31] : 1'b0;
		t = q ^ m;
		iss(w);
		idle;
		chk1(quotFlag, q);
		chk1(signFlag, m);
		chk1(condFlag, t);
		repeat (n) begin
			iss(16'h3104);
			top = rn[31];
			s = {1'b0, rn[30:0], t} + ((q == m) ? -{1'b0, d} : {1'b0, d});
			rn = s[31:0];
			q = top ^ s[32] ^ m;
			t = (q == m);
		end
		idle;
		chk1(resultWrite, 1'b1);
		chk32({28'h0000000, resultIndex}, 32'h0000_0001);
		chk32(resultData, rn);
		chk1(quotFlag, q);
		chk1(condFlag, t);
		chk1(signFlag, m);
		if (w == 16'h0019 && d != 32'h0000_0000) begin
			chk32({16'h0000, rn[14:0], t}, a / {16'h0000, d[31:16]});
		end
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		end_of_test;
	end

	initial begin
		fails = 0;
		checkCount = 0;
		pc = 32'h0000_1000;
		rst = 1'b1;
		instrValid = 1'b0;
		instr = 16'h0000;
		pcIn = 32'h0000_0000;
		loadEn = 1'b0;
		loadIndex = 4'h0;
		loadData = 32'h0000_0000;
		repeat (8) @(negedge clk);
		rst = 1'b0;
		chk32(pcOut, 32'h0000_0000);
		t_cmp(16'h3120, 32'h0000_0005, 32'h0000_0005, 1'b1);
		t_cmp(16'h3120, 32'h0000_0005, 32'h0000_0006, 1'b0);
		t_cmp(16'h3123, 32'h8000_0000, 32'h7FFF_FFFF, 1'b0);
		t_cmp(16'h3127, 32'h7FFF_FFFF, 32'h8000_0000, 1'b1);
		t_cmp(16'h3127, 32'h0000_0005, 32'h0000_0005, 1'b0);
		t_cmp(16'h3122, 32'h8000_0000, 32'h7FFF_FFFF, 1'b1);
		t_cmp(16'h3126, 32'h0000_0005, 32'h0000_0005, 1'b0);
		t_cmp(16'h3126, 32'h8000_0000, 32'h7FFF_FFFF, 1'b1);
		t_cmp(16'h3123, 32'h0000_0005, 32'h0000_0005, 1'b1);
		t_cmp(16'h4115, 32'h0000_0000, 32'h0000_0000, 1'b0);
		t_cmp(16'h4115, 32'h0000_0001, 32'h0000_0000, 1'b1);
		t_cmp(16'h4111, 32'h0000_0000, 32'h0000_0000, 1'b1);
		t_cmp(16'h4111, 32'h8000_0000, 32'h0000_0000, 1'b0);
		t_cmp(16'h212C, 32'h4142_4344, 32'h5859_435A, 1'b1);
		t_cmp(16'h212C, 32'h4142_4344, 32'h5859_445A, 1'b0);
		t_cmp(16'h88FF, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1);
		t_cmp(16'h887F, 32'hFFFF_FF7F, 32'h0000_0000, 1'b0);
		t_refuse;
		t_div(16'h2107, 32'h8000_0005, 32'h0003_0000, 16);
		t_div(16'h0019, 32'h0012_3456, 32'h0ABC_0000, 16);
		t_div(16'h0019, 32'h0000_1234, 32'h0000_0000, 4);
		// A second reset in mid-run must bring the condition flag, accepted, result data and program counter back to rest.
		@(negedge clk);
		rst = 1'b1;
		@(negedge clk);
		rst = 1'b0;
		chk1(condFlag, 1'b0);
		chk1(accepted, 1'b0);
		chk32(resultData, 32'h0000_0000);
		chk32(pcOut, 32'h0000_0000);
		t_cmp(16'h3120, 32'h0000_0007, 32'h0000_0007, 1'b1);
		end_of_test;
	end
endmodule

`default_nettype wire
